// File: shared/vme_sysctl_pkg.sv
// Constants and types for the VMEbus system controller, requester and mailbox block.
// Assumes a 100 MHz core clock and a byte-addressed Avalon-MM register window.
package vme_sysctl_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_US      = 1000;
  localparam int CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
  localparam int ARB_TO_SHORT_US = 16;
  localparam int ARB_TO_LONG_US  = 256;
  localparam int BTO_MIN_US     = 4;
  localparam int BTO_MAX_US     = 1024;
  localparam int SYSCLK_HALF    = 3;   // Half period of the backplane clock, cycles
  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL     = 6'h00;
  localparam logic [5:0] OFF_BTO      = 6'h04;
  localparam logic [5:0] OFF_REQ      = 6'h08;
  localparam logic [5:0] OFF_STAT     = 6'h0C;
  localparam logic [5:0] OFF_INT_STAT = 6'h10;
  localparam logic [5:0] OFF_INT_CLR  = 6'h14;
  localparam logic [5:0] OFF_INT_EN   = 6'h18;
  localparam logic [5:0] OFF_ROUTE    = 6'h1C;
  localparam logic [5:0] OFF_MBX_BASE = 6'h20;
  // ==========================================================================
  // Control fields and reset values
  localparam int CTRL_SYSCON_BIT = 0;
  localparam int CTRL_ARB_LSB    = 1;
  localparam int CTRL_ATO_BIT    = 3;
  localparam int CTRL_LVL_LSB    = 4;
  localparam int CTRL_POL_LSB    = 6;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [10:0] BTO_RST  = 11'h040;
  // ==========================================================================
  // Interrupt events
  localparam int EV_ARB_TO  = 0;
  localparam int EV_BTO     = 1;
  localparam int EV_MBX_LSB = 2;
  localparam int NUM_EV     = 6;
  localparam int NUM_MBX    = 4;
  // ==========================================================================
  // Modes and states
  typedef enum logic [1:0] {arb_round_robin, arb_single_level, arb_fixed_priority} arb_mode_t;
  typedef enum logic [1:0] {
    release_when_requested, release_after_transfer, capture_and_hold
  } policy_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_BUSY} arb_state_t;
endpackage

// File: rtl/vme_sysctl_requester_mailbox.sv
// Slot-1 system controller, bus requester and four shared mailboxes for VMEbus.
// Assumes backplane pins are synchronous to clock; open-drain pins are split
// into an active-low level input and an output enable that pulls the line low.
`timescale 1ns/10ps

// Contract
// - System controller can be enabled or disabled
// - Arbiter: round robin, single level, priority
// - Controller drives SYSCLK, IACK chain, access timer
// - Grant without BBSY in 16/256 us flags
// - Request on software-chosen level BR3..BR0
// - Release on request, when done, or hold
// - Four 32-bit mailboxes shared by both sides
// - VMEbus mailbox access raises local interrupt
// - Access timeout programmable 4 to 1024 us
// - Mailbox and other interrupts routable INTA/SERR
module vme_sysctl_requester_mailbox
  import vme_sysctl_pkg::*;
#(
  parameter int TICK_CYCLES = CYC_PER_US  // Cycles per microsecond tick
) (
  input  wire logic        clock,          // Core clock, 100 MHz
  input  wire logic        sys_rst,        // Synchronous reset, high
  input  wire logic [5:0]  avs_address,    // Byte address
  input  wire logic        avs_read,       // Read request
  input  wire logic        avs_write,      // Write request
  input  wire logic [31:0] avs_writedata,  // Write data
  input  wire logic [3:0]  avs_byteenable, // Write byte lanes
  output logic      [31:0] avs_readdata,   // Read data
  output logic             avs_waitrequest,// Stall
  input  wire logic [3:0]  br_n,           // BR3..BR0 line levels
  output logic      [3:0]  br_oe,          // Pull BR lines low
  input  wire logic        bbsy_n,         // BBSY line level
  output logic             bbsy_oe,        // Pull BBSY low
  input  wire logic [3:0]  bgin_n,         // Grant daisy chain in
  output logic      [3:0]  bgout_n,        // Grant daisy chain out
  input  wire logic        as_n,           // Address strobe level
  input  wire logic        dtack_n,        // Data acknowledge level
  input  wire logic        berr_n,         // Bus error level
  output logic             berr_oe,        // Pull BERR low
  input  wire logic        iack_n,         // IACK line level
  output logic             iackout_n,      // Daisy chain start
  output logic             sysclk,         // Backplane clock
  output logic             sysclk_oe,      // SYSCLK driver enable
  input  wire logic        loc_busy,       // Local transfers pending
  output logic             vme_owned,      // We hold the bus
  input  wire logic [1:0]  mbx_vme_sel,    // Mailbox picked by VME slave
  input  wire logic        mbx_vme_wr,     // VME master writes mailbox
  input  wire logic        mbx_vme_rd,     // VME master reads mailbox
  input  wire logic [31:0] mbx_vme_wdata,  // VME write data
  output logic      [31:0] mbx_vme_rdata,  // VME read data
  output logic             irq,            // Any enabled event
  output logic             inta_n,         // PCI INTA#
  output logic             serr_n          // PCI SERR#
);

  // ==========================================================================
  // Helper functions
  // Level number to one-hot line mask
  function automatic logic [3:0] onehot(input logic [1:0] lvl);
    onehot = 4'h1 << lvl;
  endfunction

  // Pick the first request counting down from last-1; {found, level}
  function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] last);
    logic [1:0] idx;
    pick = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      idx = last - 2'(i);
      if (req[idx]) begin
        pick = {1'b1, idx};
      end
    end
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ==========================================================================
  // Register bus slave: one wait cycle per access
  logic              ack_r;                 // Second cycle of an access
  logic [7:0]        ctrl_r;                // Control register
  logic [10:0]       bto_r;                 // Access timeout, us
  logic              req_r;                 // Software bus request
  logic [NUM_EV-1:0] stat_r;                // Sticky events
  logic [NUM_EV-1:0] en_r;                  // Event enables
  logic [1:0]        route_r;               // 1 sends to SERR
  logic [31:0]       mbx_r [NUM_MBX];       // Mailbox words
  logic [31:0]       rd_mux;                // Read selection
  logic [31:0]       wmerge;                // Write data after lanes
  logic [31:0]       bto_wr;                // Timeout word after lanes
  logic              wr_go;                 // Write takes effect
  logic [NUM_EV-1:0] ev;                    // Event pulses
  logic [NUM_EV-1:0] clr;                   // Clear mask
  arb_state_t        arb_st_r;              // Arbiter state, GRANT flag read back in STAT

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go  = avs_write & ack_r;
  assign wmerge = merge(32'h0, avs_writedata, avs_byteenable);
  // Lane merge kept as a named word so only the stored bits are taken
  assign bto_wr = merge({21'h0, bto_r}, avs_writedata, avs_byteenable);

  // Ack toggles so every request sees exactly one stalled cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Unmapped offsets read zero
  assign rd_mux =
    (avs_address == OFF_CTRL)     ? {24'h0, ctrl_r} :
    (avs_address == OFF_BTO)      ? {21'h0, bto_r} :
    (avs_address == OFF_REQ)      ? {31'h0, req_r} :
    (avs_address == OFF_STAT)     ? {29'h0, arb_st_r == ARB_GRANT, berr_oe, vme_owned} :
    (avs_address == OFF_INT_STAT) ? {26'h0, stat_r} :
    (avs_address == OFF_INT_EN)   ? {26'h0, en_r} :
    (avs_address == OFF_ROUTE)    ? {30'h0, route_r} :
    (avs_address[5:4] == OFF_MBX_BASE[5:4] && avs_address[1:0] == 2'h0)
                                  ? mbx_r[avs_address[3:2]] : 32'h0;

  // Read data captured in the stalled cycle, stands until the next read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_mux;
    end
  end

  // Control registers; the request bit is the only one software keeps toggling
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r  <= CTRL_RST;
      bto_r   <= BTO_RST;
      req_r   <= 1'b0;
      en_r    <= '0;
      route_r <= 2'h0;
    end else if (wr_go) begin
      if (avs_address == OFF_CTRL && avs_byteenable[0]) ctrl_r <= avs_writedata[7:0];
      if (avs_address == OFF_BTO) bto_r <= bto_wr[10:0];
      if (avs_address == OFF_REQ && avs_byteenable[0]) req_r <= avs_writedata[0];
      if (avs_address == OFF_INT_EN && avs_byteenable[0]) en_r <= avs_writedata[5:0];
      if (avs_address == OFF_ROUTE && avs_byteenable[0]) route_r <= avs_writedata[1:0];
    end
  end

  // ==========================================================================
  // Decoded configuration
  logic       syscon;                       // Controller role on
  arb_mode_t  arb_mode;                     // Arbitration scheme
  policy_t    policy;                       // Release policy
  logic [1:0] req_lvl;                      // Our request level
  logic [8:0] ato_lim;                      // Arbitration timeout, us
  logic [10:0] bto_eff;                     // Clamped access timeout

  assign syscon   = ctrl_r[CTRL_SYSCON_BIT];
  assign arb_mode = arb_mode_t'(ctrl_r[CTRL_ARB_LSB +: 2]);
  assign policy   = policy_t'(ctrl_r[CTRL_POL_LSB +: 2]);
  assign req_lvl  = ctrl_r[CTRL_LVL_LSB +: 2];
  assign ato_lim  = ctrl_r[CTRL_ATO_BIT] ? 9'(ARB_TO_LONG_US) : 9'(ARB_TO_SHORT_US);
  assign bto_eff  = (bto_r < 11'(BTO_MIN_US)) ? 11'(BTO_MIN_US) :
                    (bto_r > 11'(BTO_MAX_US)) ? 11'(BTO_MAX_US) : bto_r;

  // ==========================================================================
  // Microsecond tick shared by both timers
  logic [15:0] tick_cnt_r;                  // Prescaler
  logic        tick;                        // One cycle per us

  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (sys_rst || tick) begin
      tick_cnt_r <= 16'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h1;
    end
  end

  // ==========================================================================
  // Arbiter
  logic [1:0] gnt_lvl_r;                    // Level granted
  logic [1:0] last_r;                       // Last served, for rotation
  logic [8:0] ato_cnt_r;                    // Grant wait, us
  logic [2:0] win;                          // Chosen request
  logic [3:0] arb_gnt;                      // Grant lines from arbiter
  logic       ato_hit;                      // Grant waited too long

  assign win = (arb_mode == arb_round_robin)  ? pick(~br_n, last_r) :
               (arb_mode == arb_single_level) ? pick(~br_n & 4'h8, 2'h0) :
                                                pick(~br_n, 2'h0);
  // grant only in GRANT, single level
  assign arb_gnt = (arb_st_r == ARB_GRANT) ? onehot(gnt_lvl_r) : 4'h0;
  assign ato_hit = tick && (ato_cnt_r == ato_lim - 9'h1);

  // Grant, wait for BBSY, then wait for its release
  always_ff @(posedge clock) begin
    if (sys_rst || !syscon) begin
      arb_st_r  <= ARB_IDLE;
      gnt_lvl_r <= 2'h0;
      last_r    <= 2'h0;
      ato_cnt_r <= 9'h0;
    end else begin
      unique case (arb_st_r)
        ARB_IDLE: begin
          ato_cnt_r <= 9'h0;
          // Only a free bus gets a new grant
          if (bbsy_n && win[2]) begin
            arb_st_r  <= ARB_GRANT;
            gnt_lvl_r <= win[1:0];
          end
        end
        ARB_GRANT: begin
          if (!bbsy_n) begin
            arb_st_r <= ARB_BUSY;
          end else if (ato_hit) begin
            arb_st_r <= ARB_IDLE;
          end else if (tick) begin
            ato_cnt_r <= ato_cnt_r + 9'h1;
          end
        end
        ARB_BUSY: begin
          if (bbsy_n) begin
            arb_st_r <= ARB_IDLE;
            last_r   <= gnt_lvl_r;
          end
        end
        default: arb_st_r <= ARB_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Requester
  logic       own_r;                        // Bus held
  logic       asking;                       // Driving our BR line
  logic [3:0] gin;                          // Grants reaching us
  logic [3:0] take;                         // Grant kept, not passed on
  logic       other_req;                    // Someone else requests
  logic       release_now;                  // Policy says let go

  assign asking    = req_r & ~own_r;
  assign br_oe     = asking ? onehot(req_lvl) : 4'h0;
  // As slot 1 our arbiter feeds the head of the chain
  assign gin       = syscon ? arb_gnt : ~bgin_n;
  assign take      = asking ? onehot(req_lvl) : 4'h0;
  assign bgout_n   = ~(gin & ~take);
  // Our own line is released while we own, so any BR seen is another master
  assign other_req = |(~br_n);
  assign release_now = !loc_busy && (
    (policy == release_when_requested) ? (other_req || !req_r) :
    (policy == release_after_transfer) ? 1'b1 : !req_r);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      own_r <= 1'b0;
    end else if (asking && |(gin & take)) begin
      own_r <= 1'b1;
    end else if (own_r && release_now) begin
      own_r <= 1'b0;
    end
  end

  assign bbsy_oe   = own_r;
  assign vme_owned = own_r;

  // ==========================================================================
  // Access timeout, SYSCLK and IACK chain
  logic [10:0] bto_cnt_r;                   // Strobe age, us
  logic        berr_r;                      // Bus error driven
  logic [1:0]  div_r;                       // SYSCLK divider
  logic        sysclk_r;                    // SYSCLK level
  logic        berr_d_r;                    // BERR one cycle late, for edge

  // time out stuck cycles; hold BERR until the strobe drops
  always_ff @(posedge clock) begin
    if (sys_rst || !syscon || as_n) begin
      bto_cnt_r <= 11'h0;
      berr_r    <= 1'b0;
    end else if (!dtack_n && !berr_r) begin
      bto_cnt_r <= 11'h0;
    end else if (tick && !berr_r) begin
      if (bto_cnt_r == bto_eff - 11'h1) begin
        berr_r <= 1'b1;
      end
      bto_cnt_r <= bto_cnt_r + 11'h1;
    end
  end

  assign berr_oe = berr_r;

  // Delayed copy so the event fires once per timeout, not per cycle held
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      berr_d_r <= 1'b0;
    end else begin
      berr_d_r <= berr_r;
    end
  end

  // SYSCLK divider; divide ratio is a trade against exact 16 MHz
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_r    <= 2'h0;
      sysclk_r <= 1'b0;
    end else if (div_r == 2'(SYSCLK_HALF - 1)) begin
      div_r    <= 2'h0;
      sysclk_r <= ~sysclk_r;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  assign sysclk    = sysclk_r;
  // drivers off when another board is slot 1
  assign sysclk_oe = syscon;
  // start of the IACK daisy chain
  assign iackout_n = syscon ? iack_n : 1'b1;

  // ==========================================================================
  // Mailboxes
  logic [NUM_MBX-1:0] mbx_ev;               // VME side touched a box

  // each box written from either side, VME wins a tie
  for (genvar g = 0; g < NUM_MBX; g++) begin : g_mbx
    assign mbx_ev[g] = (mbx_vme_wr | mbx_vme_rd) && (mbx_vme_sel == 2'(g));
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        mbx_r[g] <= 32'h0;
      end else if (mbx_vme_wr && mbx_vme_sel == 2'(g)) begin
        mbx_r[g] <= mbx_vme_wdata;
      end else if (wr_go && avs_address == OFF_MBX_BASE + 6'(4 * g)) begin
        mbx_r[g] <= merge(mbx_r[g], avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mbx_vme_rdata <= 32'h0;
    end else if (mbx_vme_rd) begin
      mbx_vme_rdata <= mbx_r[mbx_vme_sel];
    end
  end

  // ==========================================================================
  // Interrupts: set beats clear in the same cycle
  logic [NUM_EV-1:0] act;                   // Enabled and pending
  logic [NUM_EV-1:0] to_serr;               // Per-event routing

  assign ev  = {mbx_ev, berr_r & ~berr_d_r, (arb_st_r == ARB_GRANT) & bbsy_n & ato_hit};
  assign clr = (wr_go && avs_address == OFF_INT_CLR) ? wmerge[NUM_EV-1:0] : '0;
  assign act = stat_r & en_r;
  // mailbox and other events route apart
  assign to_serr = {{NUM_MBX{route_r[0]}}, {2{route_r[1]}}};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~clr) | ev;
    end
  end

  assign irq    = |act;
  assign inta_n = ~|(act & ~to_serr);
  assign serr_n = ~|(act & to_serr);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_grant_open;
    arb_st_r == ARB_GRANT && bbsy_n;
  endsequence

  property p_role_off;
    !syscon |-> (!sysclk_oe && iackout_n) ##1 arb_gnt == 4'h0;
  endproperty
  a_role_off: assert property (p_role_off) else $error("controller active while off");

  property p_single_lvl;
    (arb_st_r == ARB_IDLE && syscon && bbsy_n && arb_mode == arb_single_level && win[2])
      |=> gnt_lvl_r == 2'h3;
  endproperty
  a_single_lvl: assert property (p_single_lvl) else $error("single level granted low");

  property p_berr_cause;
    $rose(berr_oe) |-> $past(bto_cnt_r) == bto_eff - 11'h1 && !$past(as_n);
  endproperty
  a_berr_cause: assert property (p_berr_cause) else $error("bus error at wrong age");

  property p_arb_to;
    s_grant_open ##0 ato_hit |=> arb_st_r == ARB_IDLE && stat_r[EV_ARB_TO];
  endproperty
  a_arb_to: assert property (p_arb_to) else $error("arbitration timeout missed");

  property p_br_lvl;
    br_oe != 4'h0 |-> br_oe == onehot(req_lvl) && !own_r;
  endproperty
  a_br_lvl: assert property (p_br_lvl) else $error("request on wrong level");

  property p_ror;
    own_r && policy == release_when_requested && !loc_busy && other_req |=> !own_r;
  endproperty
  a_ror: assert property (p_ror) else $error("bus kept after request");

  property p_mbx_keep;
    wr_go && avs_address[5:4] == OFF_MBX_BASE[5:4] && avs_address[1:0] == 2'h0
      && avs_byteenable == 4'hF && !mbx_vme_wr
      |=> mbx_r[$past(avs_address[3:2])] == $past(avs_writedata);
  endproperty
  a_mbx_keep: assert property (p_mbx_keep) else $error("mailbox write lost");

  property p_mbx_irq;
    |(mbx_ev & en_r[EV_MBX_LSB +: NUM_MBX]) |=> irq [*2];
  endproperty
  a_mbx_irq: assert property (p_mbx_irq) else $error("mailbox interrupt missing");

  property p_bto_range;
    $rose(berr_oe) |-> $past(bto_cnt_r) >= 11'(BTO_MIN_US - 1)
      && $past(bto_cnt_r) <= 11'(BTO_MAX_US - 1);
  endproperty
  a_bto_range: assert property (p_bto_range) else $error("timeout out of range");

  property p_route;
    |(act[EV_MBX_LSB +: NUM_MBX]) && route_r[0] |-> !serr_n;
  endproperty
  a_route: assert property (p_route) else $error("mailbox not on SERR");

  property p_one_grant;
    $onehot0(arb_gnt) and ($rose(|arb_gnt) |-> $past(bbsy_n));
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("second grant issued");

endmodule // vme_sysctl_requester_mailbox

// File: dv/vme_backplane_model.sv
// Backplane model: other masters and their address strobe on the VMEbus.
// Assumes open-drain lines with pull-ups and grants taken from bgout_n.
`timescale 1ns/10ps
module vme_backplane_model (
  input  wire logic       clock,   // Core clock
  input  wire logic [3:0] br_oe,   // Block pulls BR
  input  wire logic       bbsy_oe, // Block pulls BBSY
  input  wire logic       berr_oe, // Block pulls BERR
  input  wire logic [3:0] bgout_n, // Grants from block
  input  wire logic [3:0] ext_br,  // Others request
  input  wire logic       take_en, // Others accept grant
  input  wire logic       ext_as,  // Other master strobe
  output logic      [3:0] br_n,    // Wired BR levels
  output logic            bbsy_n,  // Wired BBSY level
  output logic            berr_n,  // Wired BERR level
  output logic            as_n     // Wired AS level
);
  logic [3:0] own_r; // Level that won the bus
  // ========
  // Wired lines
  // Released lines float to the pull-up level
  assign br_n   = ~(br_oe | (ext_br & ~own_r));
  assign bbsy_n = ~(bbsy_oe | (|own_r));
  assign berr_n = ~berr_oe;
  assign as_n   = ~ext_as;
  // Grant is kept while allowed, then BBSY let go
  always_ff @(posedge clock) begin
    if (!take_en) own_r <= 4'h0;
    else own_r <= own_r | (~bgout_n & ext_br);
  end
endmodule // vme_backplane_model

// File: dv/vme_sysctl_requester_mailbox_test.sv
// Testbench: registers, mailboxes, arbiter, requester and access timer.
// Assumes the backplane model beside the block and ticks of 2 cycles.
`timescale 1ns/10ps
module vme_sysctl_requester_mailbox_test import vme_sysctl_pkg::*;;
  logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest, s;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, mbx_vme_wdata, mbx_vme_rdata;
  logic [3:0]  br_n, br_oe, bgout_n, ext_br;
  logic        bbsy_n, bbsy_oe, as_n, berr_n, berr_oe, iack_n, iackout_n;
  logic        sysclk, sysclk_oe, loc_busy, vme_owned, irq, inta_n, serr_n;
  logic        mbx_vme_wr, mbx_vme_rd, take_en, ext_as;
  logic [1:0]  mbx_vme_sel;
  int          failures, cmp_count;
  // ========
  // Instances
  vme_sysctl_requester_mailbox #(.TICK_CYCLES(2)) dut (.clock, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .br_n, .br_oe, .bbsy_n, .bbsy_oe, .bgin_n(4'hF), .bgout_n, .as_n,
    .dtack_n(1'b1), .berr_n, .berr_oe, .iack_n, .iackout_n, .sysclk, .sysclk_oe,
    .loc_busy, .vme_owned, .mbx_vme_sel, .mbx_vme_wr, .mbx_vme_rd, .mbx_vme_wdata,
    .mbx_vme_rdata, .irq, .inta_n, .serr_n);
  vme_backplane_model bp (.clock, .br_oe, .bbsy_oe, .berr_oe, .bgout_n, .ext_br,
    .take_en, .ext_as, .br_n, .bbsy_n, .berr_n, .as_n);
  // ========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    q = avs_readdata;
    if (n >= 16) failures++;
    if (n >= 16) tally_and_finish;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // ========
  // Clock and sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {sys_rst, avs_read, avs_write, loc_busy, mbx_vme_wr, mbx_vme_rd} = 6'h20;
    {take_en, ext_as, iack_n, avs_address, mbx_vme_sel, ext_br} = 15'h1000;
    {avs_writedata, mbx_vme_wdata, failures, cmp_count} = 128'h0;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    rd_chk(OFF_CTRL, 32'h0); // controller off
    rd_chk(OFF_BTO, 32'h40); // default period
    bus(1'b1, 6'h30, 32'hFFFFFFFF);
    rd_chk(6'h30, 32'h0); // hole reads zero
    $display("test reset done");
    bus(1'b1, OFF_MBX_BASE + 6'h4, 32'hA5A51234);
    mbx_vme_sel <= 2'h1;
    mbx_vme_rd <= 1'b1;
    tick(1);
    {mbx_vme_rd, mbx_vme_wr, mbx_vme_sel, mbx_vme_wdata} <= {4'h6, 32'hCAFE0002};
    tick(1);
    chk(mbx_vme_rdata, 32'hA5A51234); // far side reads
    mbx_vme_wr <= 1'b0;
    rd_chk(OFF_MBX_BASE + 6'h8, 32'hCAFE0002); // far side wrote
    rd_chk(OFF_INT_STAT, 32'h18); // both accesses flagged
    chk(irq, 1'b0); // masked
    bus(1'b1, OFF_INT_EN, 32'h18);
    mbx_vme_rd <= 1'b1;
    tick(1);
    mbx_vme_rd <= 1'b0;
    tick(1);
    chk(mbx_vme_rdata, 32'hCAFE0002); // far side reads again
    chk({irq, inta_n, serr_n}, 3'h5); // on INTA
    bus(1'b1, OFF_ROUTE, 32'h1);
    chk({irq, inta_n, serr_n}, 3'h6); // on SERR
    bus(1'b1, OFF_INT_CLR, 32'h18);
    chk({irq, serr_n}, 2'h1); // cleared
    $display("test mailbox done");
    bus(1'b1, OFF_CTRL, 32'h3);
    {iack_n, ext_br} <= 5'h02;
    s = sysclk;
    tick(3);
    chk(sysclk, {31'h0, ~s}); // clock driven
    chk({sysclk_oe, iackout_n, bgout_n}, 6'h2F); // BR1 ignored
    ext_br <= 4'h0;
    bus(1'b1, OFF_CTRL, 32'h5);
    ext_br <= 4'hA;
    tick(3);
    chk(bgout_n, 4'h7); // BR3 alone wins
    tick(24);
    rd_chk(OFF_INT_STAT, 32'h0); // not yet
    tick(8);
    rd_chk(OFF_INT_STAT, 32'h1); // no BBSY seen
    take_en <= 1'b1;
    tick(4);
    chk({bbsy_n, bgout_n}, 5'h0F); // grant withdrawn
    {take_en, ext_br} <= 5'h0;
    $display("test arbiter done");
    bus(1'b1, OFF_CTRL, 32'h15);
    bus(1'b1, OFF_REQ, 32'h1);
    tick(4);
    chk({vme_owned, bbsy_oe, br_oe}, 6'h30); // owned via BR1
    ext_br <= 4'h8;
    tick(4);
    chk(vme_owned, 1'b0); // gives way
    {loc_busy, ext_br} <= 5'h10;
    bus(1'b1, OFF_CTRL, 32'h55);
    tick(50);
    ext_br <= 4'h8;
    tick(6);
    chk(vme_owned, 1'b1); // held while busy
    bus(1'b1, OFF_CTRL, 32'h95);
    loc_busy <= 1'b0;
    tick(6);
    chk(vme_owned, 1'b1); // captured
    bus(1'b1, OFF_REQ, 32'h0);
    tick(2);
    chk({vme_owned, bbsy_oe}, 2'h0); // freed
    ext_br <= 4'h0;
    $display("test requester done");
    bus(1'b1, OFF_CTRL, 32'h5);
    bus(1'b1, OFF_BTO, 32'h4);
    ext_as <= 1'b1;
    tick(3);
    chk(berr_oe, 1'b0); // too soon
    tick(8);
    chk({berr_oe, berr_n}, 2'h2); // timed out
    ext_as <= 1'b0;
    rd_chk(OFF_INT_STAT, 32'h3); // flagged
    $display("test access timer done");
    tally_and_finish;
  end
endmodule // vme_sysctl_requester_mailbox_test
